/* File: rtl/xcvr_pkg.sv */
// Shared constants and types for the channel core interface and its fabric partner.
package xcvr_pkg;
  // Parallel bus layout.
  localparam int DATA_W = 80;
  localparam int CTRL_W = 8;
  localparam int PAYLOAD_W = 64;
  localparam int UNUSED_W = 16;
  localparam int HALF_W = 32;
  localparam int WORD_W = 72;
  localparam int CTRL_LSB = 64;
  localparam int MARK_POS = 79;
  localparam int BUF_DEPTH = 2;
  // Asynchronous input vector positions.
  localparam int ASYNC_W = 6;
  localparam int A_LPBK = 0;
  localparam int A_TXA = 1;
  localparam int A_TXD = 2;
  localparam int A_RXA = 3;
  localparam int A_RXD = 4;
  localparam int A_REL = 5;
  // Timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAL_TIME_NS = 2000;
  localparam int LOCK_TIME_NS = 500;
  localparam int SETTLE_TIME_NS = 100;
  localparam int REL_TIME_NS = 300;
  localparam logic [7:0] CAL_CYCLES = 8'((CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] LOCK_CYCLES = 8'((LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SETTLE_CYCLES = 8'((SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] REL_CYCLES = 8'((REL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [6:0] SER_LAST = 7'(WORD_W - 1);
  // Clock output sources.
  typedef enum logic [2:0] {
    CLK_PCS = 3'h1,
    CLK_PCS_X2 = 3'h2,
    CLK_PMA_DIV = 3'h4
  } clk_src_t;
  // Fabric reset sequencer states.
  typedef enum logic [5:0] {
    F_HOLD = 6'h01,
    F_CAL = 6'h02,
    F_ANALOG = 6'h04,
    F_DIGITAL = 6'h08,
    F_LOCK = 6'h10,
    F_RUN = 6'h20
  } fab_state_t;
endpackage : xcvr_pkg

/* File: rtl/xcvr_link_if.sv */
// Link between the channel core interface and the fabric logic.
`timescale 1ns/1ns
interface xcvr_link_if;
  logic loopback_enable;
  logic tx_analog_reset;
  logic tx_digital_reset;
  logic rx_analog_reset;
  logic rx_digital_reset;
  logic release_ctrl;
  logic [xcvr_pkg::DATA_W-1:0] tx_data;
  logic [xcvr_pkg::CTRL_W-1:0] tx_control;
  logic [xcvr_pkg::UNUSED_W-1:0] unused_tx_data;
  logic tx_valid;
  logic tx_ready;
  logic tx_cal_busy;
  logic rx_cal_busy;
  logic tx_analog_status;
  logic tx_digital_status;
  logic rx_analog_status;
  logic rx_digital_status;
  logic dll_lock;
  logic transmit_clock_out;
  logic transmit_second_clock_out;
  modport device_mp (
    input loopback_enable, tx_analog_reset, tx_digital_reset, rx_analog_reset, rx_digital_reset,
    input release_ctrl, tx_data, tx_control, unused_tx_data, tx_valid,
    output tx_ready, tx_cal_busy, rx_cal_busy, tx_analog_status, tx_digital_status,
    output rx_analog_status, rx_digital_status, dll_lock, transmit_clock_out, transmit_second_clock_out
  );
  modport fabric_mp (
    output loopback_enable, tx_analog_reset, tx_digital_reset, rx_analog_reset, rx_digital_reset,
    output release_ctrl, tx_data, tx_control, unused_tx_data, tx_valid,
    input tx_ready, tx_cal_busy, rx_cal_busy, tx_analog_status, tx_digital_status,
    input rx_analog_status, rx_digital_status, dll_lock, transmit_clock_out, transmit_second_clock_out
  );
endinterface : xcvr_link_if

/* File: rtl/xcvr_channel.sv */
// Channel end: resets, calibration, loopback, transmit data path and clock outputs.
`timescale 1ns/1ns
module xcvr_channel (
  // Clock, reset and clock enable.
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Configuration.
  input wire logic i_simplified,
  input wire logic i_double_rate,
  input wire logic i_bonded,
  input wire logic i_master_align,
  input wire logic [2:0] i_clk_sel_first,
  input wire logic [2:0] i_clk_sel_second,
  // Calibration requests.
  input wire logic i_tx_cal_request,
  input wire logic i_rx_cal_request,
  // Serial side.
  input wire logic i_serial_rx,
  output logic o_serial_tx,
  output logic o_rx_bit,
  output logic [7:0] o_rx_shift,
  // Fabric link.
  xcvr_link_if.device_mp link
);
  typedef struct packed {
    logic [xcvr_pkg::ASYNC_W-1:0] s1;
    logic [xcvr_pkg::ASYNC_W-1:0] s2;
    logic [xcvr_pkg::ASYNC_W-1:0] s3;
    logic [xcvr_pkg::ASYNC_W-1:0] filt;
    logic [7:0] tx_cal_cnt;
    logic [7:0] rx_cal_cnt;
    logic [7:0] lock_cnt;
    logic [2:0] div_cnt;
    logic [xcvr_pkg::BUF_DEPTH-1:0][xcvr_pkg::WORD_W-1:0] buf_word;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic [xcvr_pkg::HALF_W-1:0] lower_half;
    logic lower_held;
    logic [xcvr_pkg::WORD_W-1:0] shreg;
    logic [6:0] bit_cnt;
    logic shifting;
    logic tx_ready;
    logic tx_cal_busy;
    logic rx_cal_busy;
    logic dll_lock;
    logic clk_out1;
    logic clk_out2;
    logic serial_tx;
    logic rx_bit;
    logic [7:0] rx_shift;
    logic [3:0] stat;
  } chan_state_t;

  chan_state_t st;
  chan_state_t next_st;
  logic [xcvr_pkg::ASYNC_W-1:0] async_in;
  logic [xcvr_pkg::WORD_W-1:0] in_word;
  logic tx_pma_rst;
  logic tx_pcs_rst;
  logic rx_pma_rst;
  logic rx_pcs_rst;
  logic accept;
  logic push;
  logic pop;
  logic simple_eff;

  ////////////////////////////////////////////////////////////////////////////
  // Clock source selection.
  function automatic logic pick_clock(input logic [2:0] sel, input logic [2:0] cnt);
    logic r;
    r = 1'b0;
    unique case (sel)
      xcvr_pkg::CLK_PCS: r = cnt[1];
      xcvr_pkg::CLK_PCS_X2: r = cnt[0];
      xcvr_pkg::CLK_PMA_DIV: r = cnt[2];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pick_clock

  ////////////////////////////////////////////////////////////////////////////
  // Asynchronous control inputs gathered for the synchronisers.
  assign async_in = {link.release_ctrl, link.rx_digital_reset, link.rx_analog_reset,
                     link.tx_digital_reset, link.tx_analog_reset, link.loopback_enable};

  always_comb begin
    next_st = st;
    tx_pma_rst = st.filt[xcvr_pkg::A_TXA];
    tx_pcs_rst = st.filt[xcvr_pkg::A_TXD] | st.filt[xcvr_pkg::A_REL];
    rx_pma_rst = st.filt[xcvr_pkg::A_RXA];
    rx_pcs_rst = st.filt[xcvr_pkg::A_RXD];
    simple_eff = i_simplified & ~i_double_rate;
    accept = link.tx_valid & st.tx_ready;
    in_word = link.tx_data[xcvr_pkg::WORD_W-1:0];
    if (simple_eff) begin
      in_word = {link.tx_control, link.tx_data[xcvr_pkg::PAYLOAD_W-1:0]};
    end
    if (i_double_rate) begin
      in_word = {link.tx_data[xcvr_pkg::CTRL_LSB +: xcvr_pkg::CTRL_W],
                 link.tx_data[xcvr_pkg::HALF_W-1:0], st.lower_half};
    end
    push = accept & (~i_double_rate | (link.tx_data[xcvr_pkg::MARK_POS] & st.lower_held));
    pop = ~st.shifting & (st.count != 2'h0) & ~tx_pma_rst;
    if (i_ce) begin
      // Three-stage synchronisers; a change counts once stages two and three agree.
      next_st.s1 = async_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.filt = (st.s2 & st.s3) | (st.filt & (st.s2 ^ st.s3));
      next_st.stat = {rx_pcs_rst, rx_pma_rst, tx_pcs_rst, tx_pma_rst};
      // Calibration engines.
      if (i_tx_cal_request) begin
        next_st.tx_cal_cnt = xcvr_pkg::CAL_CYCLES;
      end else if (st.tx_cal_cnt != 8'h00) begin
        next_st.tx_cal_cnt = st.tx_cal_cnt - 8'h01;
      end
      next_st.tx_cal_busy = next_st.tx_cal_cnt != 8'h00;
      if (i_rx_cal_request) begin
        next_st.rx_cal_cnt = xcvr_pkg::CAL_CYCLES;
      end else if (st.rx_cal_cnt != 8'h00) begin
        next_st.rx_cal_cnt = st.rx_cal_cnt - 8'h01;
      end
      next_st.rx_cal_busy = next_st.rx_cal_cnt != 8'h00;
      // Clock divider and output selection.
      next_st.div_cnt = st.div_cnt + 3'h1;
      if (i_bonded & i_master_align) begin
        next_st.div_cnt = 3'h0;
      end
      next_st.clk_out1 = pick_clock(i_clk_sel_first, next_st.div_cnt);
      next_st.clk_out2 = pick_clock(i_clk_sel_second, next_st.div_cnt);
      // Double rate lower word holding.
      if (accept & i_double_rate & ~link.tx_data[xcvr_pkg::MARK_POS]) begin
        next_st.lower_half = link.tx_data[xcvr_pkg::HALF_W-1:0];
        next_st.lower_held = 1'b1;
      end else if (push) begin
        next_st.lower_held = 1'b0;
      end
      // Two-entry buffer.
      if (push) begin
        next_st.buf_word[st.wr_ptr] = in_word;
        next_st.wr_ptr = ~st.wr_ptr;
      end
      if (pop) begin
        next_st.shreg = st.buf_word[st.rd_ptr];
        next_st.rd_ptr = ~st.rd_ptr;
        next_st.bit_cnt = xcvr_pkg::SER_LAST;
        next_st.shifting = 1'b1;
      end else if (st.shifting) begin
        next_st.shreg = st.shreg >> 1;
        next_st.bit_cnt = st.bit_cnt - 7'h01;
        next_st.shifting = st.bit_cnt != 7'h00;
      end
      next_st.count = st.count + {1'b0, push} - {1'b0, pop};
      next_st.serial_tx = st.shifting & st.shreg[0];
      if (tx_pma_rst) begin
        next_st.shifting = 1'b0;
        next_st.shreg = '0;
        next_st.serial_tx = 1'b0;
      end
      if (tx_pcs_rst) begin
        next_st.count = 2'h0;
        next_st.wr_ptr = 1'b0;
        next_st.rd_ptr = 1'b0;
        next_st.lower_held = 1'b0;
      end
      next_st.tx_ready = ~tx_pcs_rst & (next_st.count != 2'h2);
      // Delay locked loop lock timer.
      if (tx_pcs_rst) begin
        next_st.lock_cnt = 8'h00;
      end else if (st.lock_cnt != xcvr_pkg::LOCK_CYCLES) begin
        next_st.lock_cnt = st.lock_cnt + 8'h01;
      end
      next_st.dll_lock = next_st.lock_cnt == xcvr_pkg::LOCK_CYCLES;
      // Receive path with serial loopback.
      next_st.rx_bit = st.filt[xcvr_pkg::A_LPBK] ? st.serial_tx : i_serial_rx;
      if (rx_pma_rst) begin
        next_st.rx_bit = 1'b0;
      end
      next_st.rx_shift = {st.rx_shift[6:0], st.rx_bit};
      if (rx_pcs_rst) begin
        next_st.rx_shift = 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st <= '0;
      st.s1 <= 6'h1e;
      st.s2 <= 6'h1e;
      st.s3 <= 6'h1e;
      st.filt <= 6'h1e;
      st.stat <= 4'hf;
      st.tx_cal_cnt <= xcvr_pkg::CAL_CYCLES;
      st.rx_cal_cnt <= xcvr_pkg::CAL_CYCLES;
      st.tx_cal_busy <= 1'b1;
      st.rx_cal_busy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign link.tx_ready = st.tx_ready;
  assign link.tx_cal_busy = st.tx_cal_busy;
  assign link.rx_cal_busy = st.rx_cal_busy;
  assign link.tx_analog_status = st.stat[0];
  assign link.tx_digital_status = st.stat[1];
  assign link.rx_analog_status = st.stat[2];
  assign link.rx_digital_status = st.stat[3];
  assign link.dll_lock = st.dll_lock;
  assign link.transmit_clock_out = st.clk_out1;
  assign link.transmit_second_clock_out = st.clk_out2;
  assign o_serial_tx = st.serial_tx;
  assign o_rx_bit = st.rx_bit;
  assign o_rx_shift = st.rx_shift;
endmodule : xcvr_channel

/* File: rtl/xcvr_fabric.sv */
// Fabric end: reset sequencer, loopback control and transmit word feeder.
`timescale 1ns/1ns
module xcvr_fabric (
  // Clock, reset and clock enable.
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Configuration.
  input wire logic i_simplified,
  input wire logic i_double_rate,
  input wire logic i_interlaken,
  input wire logic i_loopback_request,
  input wire logic i_gearbox_reconfig,
  // User words.
  input wire logic [xcvr_pkg::WORD_W-1:0] i_word,
  input wire logic i_word_valid,
  output logic o_word_ready,
  output logic o_link_up,
  // Channel link.
  xcvr_link_if.fabric_mp link
);
  typedef struct packed {
    xcvr_pkg::fab_state_t fsm;
    logic [7:0] wait_cnt;
    logic [7:0] rel_cnt;
    logic [3:0] rst;
    logic release_ctrl;
    logic loopback;
    logic [xcvr_pkg::WORD_W-1:0] hold;
    logic held;
    logic word_ready;
    logic valid;
    logic [xcvr_pkg::DATA_W-1:0] bus;
    logic [xcvr_pkg::CTRL_W-1:0] ctrl;
    logic link_up;
  } fab_state_s_t;

  fab_state_s_t st;
  fab_state_s_t next_st;
  logic cal_busy;
  logic accepted;
  logic upper_due;
  logic simple_eff;

  always_comb begin
    next_st = st;
    cal_busy = link.tx_cal_busy | link.rx_cal_busy;
    simple_eff = i_simplified & ~i_double_rate;
    accepted = st.valid & link.tx_ready;
    upper_due = accepted & i_double_rate & ~st.bus[xcvr_pkg::MARK_POS];
    if (i_ce) begin
      next_st.loopback = i_loopback_request;
      // Reset sequencer, registered so each reset leaves on the system clock.
      unique case (st.fsm)
        xcvr_pkg::F_HOLD: next_st.fsm = xcvr_pkg::F_CAL;
        xcvr_pkg::F_CAL: begin
          if (!cal_busy) begin
            next_st.fsm = xcvr_pkg::F_ANALOG;
            next_st.wait_cnt = xcvr_pkg::SETTLE_CYCLES;
          end
        end
        xcvr_pkg::F_ANALOG: begin
          next_st.wait_cnt = st.wait_cnt - 8'h01;
          if (st.wait_cnt == 8'h01) begin
            next_st.fsm = xcvr_pkg::F_DIGITAL;
          end
        end
        xcvr_pkg::F_DIGITAL: next_st.fsm = i_interlaken ? xcvr_pkg::F_LOCK : xcvr_pkg::F_RUN;
        xcvr_pkg::F_LOCK: begin
          if (link.dll_lock) begin
            next_st.fsm = xcvr_pkg::F_RUN;
          end
        end
        xcvr_pkg::F_RUN: next_st.fsm = xcvr_pkg::F_RUN;
      endcase
      if (cal_busy) begin
        next_st.fsm = xcvr_pkg::F_CAL;
      end
      next_st.rst[0] = next_st.fsm inside {xcvr_pkg::F_HOLD, xcvr_pkg::F_CAL};
      next_st.rst[2] = next_st.rst[0];
      next_st.rst[1] = next_st.fsm inside {xcvr_pkg::F_HOLD, xcvr_pkg::F_CAL, xcvr_pkg::F_ANALOG};
      next_st.rst[3] = next_st.rst[1];
      next_st.link_up = next_st.fsm == xcvr_pkg::F_RUN;
      // Release control around gearbox reconfiguration.
      if (i_gearbox_reconfig) begin
        next_st.rel_cnt = xcvr_pkg::REL_CYCLES;
      end else if (st.rel_cnt != 8'h00) begin
        next_st.rel_cnt = st.rel_cnt - 8'h01;
      end
      next_st.release_ctrl = next_st.rel_cnt != 8'h00;
      // Word feeder.
      if (upper_due) begin
        next_st.bus = '0;
        next_st.bus[xcvr_pkg::HALF_W-1:0] = st.hold[xcvr_pkg::PAYLOAD_W-1:xcvr_pkg::HALF_W];
        next_st.bus[xcvr_pkg::CTRL_LSB +: xcvr_pkg::CTRL_W] = st.hold[xcvr_pkg::WORD_W-1:xcvr_pkg::PAYLOAD_W];
        next_st.bus[xcvr_pkg::MARK_POS] = 1'b1;
      end else if (!st.valid || accepted) begin
        next_st.valid = 1'b0;
        next_st.held = 1'b0;
        // A word whose upper half was just taken is finished and is not offered again.
        if (st.held && st.link_up && !(accepted && st.bus[xcvr_pkg::MARK_POS])) begin
          next_st.valid = 1'b1;
          next_st.held = i_double_rate;
          next_st.bus = '0;
          next_st.ctrl = 8'h00;
          if (i_double_rate) begin
            next_st.bus[xcvr_pkg::HALF_W-1:0] = st.hold[xcvr_pkg::HALF_W-1:0];
          end else if (simple_eff) begin
            next_st.bus[xcvr_pkg::PAYLOAD_W-1:0] = st.hold[xcvr_pkg::PAYLOAD_W-1:0];
            next_st.ctrl = st.hold[xcvr_pkg::WORD_W-1:xcvr_pkg::PAYLOAD_W];
          end else begin
            next_st.bus[xcvr_pkg::WORD_W-1:0] = st.hold;
          end
        end else begin
          next_st.held = st.held;
        end
      end
      if (accepted && st.bus[xcvr_pkg::MARK_POS]) begin
        next_st.held = 1'b0;
      end
      if (i_word_valid && st.word_ready) begin
        next_st.hold = i_word;
        next_st.held = 1'b1;
      end
      next_st.word_ready = ~next_st.held;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st <= '0;
      st.fsm <= xcvr_pkg::F_HOLD;
      st.rst <= 4'hf;
    end else begin
      st <= next_st;
    end
  end

  assign link.loopback_enable = st.loopback;
  assign link.tx_analog_reset = st.rst[0];
  assign link.tx_digital_reset = st.rst[1];
  assign link.rx_analog_reset = st.rst[2];
  assign link.rx_digital_reset = st.rst[3];
  assign link.release_ctrl = st.release_ctrl;
  assign link.tx_data = st.bus;
  assign link.tx_control = st.ctrl;
  assign link.unused_tx_data = 16'h0000;
  assign link.tx_valid = st.valid;
  assign o_word_ready = st.word_ready;
  assign o_link_up = st.link_up;
endmodule : xcvr_fabric

/* File: testbench/xcvr_link_sva.sv */
// Concurrent checks on the link between the channel and fabric ends.
`timescale 1ns/1ns
module xcvr_link_sva (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_reset,
  // Link signals.
  input wire logic tx_analog_reset,
  input wire logic tx_digital_reset,
  input wire logic rx_analog_reset,
  input wire logic rx_digital_reset,
  input wire logic release_ctrl,
  input wire logic [xcvr_pkg::DATA_W-1:0] tx_data,
  input wire logic [xcvr_pkg::UNUSED_W-1:0] unused_tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_cal_busy,
  input wire logic rx_cal_busy,
  input wire logic tx_digital_status,
  input wire logic rx_digital_status,
  input wire logic dll_lock
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  logic [8:0] txb;
  logic [8:0] rxb;
  always_ff @(posedge i_mclk) begin
    txb <= (i_reset || !tx_cal_busy) ? 9'h000 : txb + 9'h001;
  end
  always_ff @(posedge i_mclk) begin
    rxb <= (i_reset || !rx_cal_busy) ? 9'h000 : rxb + 9'h001;
  end
  ////////////////////////////////////////////////////////////
  AST_TX_CAL_LEN: assert property ($fell(tx_cal_busy) |-> txb >= 9'(xcvr_pkg::CAL_CYCLES) - 9'h002)
    else $error("tx calibration busy ended early");
  AST_RX_CAL_LEN: assert property ($fell(rx_cal_busy) |-> rxb >= 9'(xcvr_pkg::CAL_CYCLES) - 9'h002)
    else $error("rx calibration busy ended early");
  AST_RX_CAL_MAX: assert property (rxb <= 9'(xcvr_pkg::CAL_CYCLES) + 9'h002)
    else $error("rx calibration busy held too long");
  AST_RESET_IN_CAL: assert property ((tx_cal_busy || rx_cal_busy) [*3] |->
    (tx_analog_reset && tx_digital_reset && rx_analog_reset && rx_digital_reset))
    else $error("channel let out of reset during calibration");
  AST_TXD_HOLD: assert property ((tx_digital_reset || release_ctrl) [*6] |-> tx_digital_status)
    else $error("tx digital portion left reset while held");
  AST_RXD_FREE: assert property ((!rx_digital_reset) [*6] |-> !rx_digital_status)
    else $error("rx digital status stuck in reset");
  AST_LOCK_AFTER: assert property ($rose(dll_lock) |-> !tx_digital_status && $past(tx_digital_status, 8) == 1'b0)
    else $error("lock reported too soon after release");
  AST_REL_WIDTH: assert property ($rose(release_ctrl) |-> release_ctrl [*8] ##22 release_ctrl ##1 !release_ctrl)
    else $error("release control width wrong");
  AST_ZERO_BITS: assert property (tx_valid |-> tx_data[78:72] == 7'h00)
    else $error("inactive data bits not zero");
  AST_UNUSED_ZERO: assert property (unused_tx_data == 16'h0000)
    else $error("unused data input not zero");
  AST_HOLD_OFFER: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("offer changed before it was taken");
  cover property ($rose(release_ctrl));
  cover property ($rose(dll_lock));
  cover property (tx_valid && !tx_ready);
endmodule : xcvr_link_sva

/* File: testbench/xcvr_channel_core_interface_tb_top.sv */
// Self-checking bench for the channel and fabric ends joined by the link.
`timescale 1ns/1ns
module xcvr_channel_core_interface_tb_top;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic simp = 1'b0;
  logic dbl = 1'b0;
  logic ilk = 1'b1;
  logic lpbk = 1'b0;
  logic gbx = 1'b0;
  logic bonded = 1'b0;
  logic align = 1'b0;
  logic [2:0] sel1 = 3'h1;
  logic [2:0] sel2 = 3'h2;
  logic txcal = 1'b0;
  logic rxcal = 1'b0;
  logic ser_rx = 1'b0;
  logic [71:0] word = 72'h00_0000_0000_0000_0000;
  logic word_valid = 1'b0;
  logic ce = 1'b1;
  logic word_ready, link_up, serial_tx, rx_bit, prev_tx;
  int stalls = 0;
  logic [7:0] rx_shift;
  logic [399:0] hist;
  int fails = 0;
  int n_checks = 0;
  xcvr_link_if link ();
  xcvr_link_if link2 ();
  xcvr_channel xcvr_channel_i (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(ce), .i_simplified(simp),
    .i_double_rate(dbl), .i_bonded(bonded), .i_master_align(align), .i_clk_sel_first(sel1), .i_clk_sel_second(sel2),
    .i_tx_cal_request(txcal), .i_rx_cal_request(rxcal), .i_serial_rx(ser_rx), .o_serial_tx(serial_tx),
    .o_rx_bit(rx_bit), .o_rx_shift(rx_shift), .link(link.device_mp));
  xcvr_fabric xcvr_fabric_i (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(ce), .i_simplified(simp),
    .i_double_rate(dbl), .i_interlaken(ilk), .i_loopback_request(lpbk), .i_gearbox_reconfig(gbx), .i_word(word),
    .i_word_valid(word_valid), .o_word_ready(word_ready), .o_link_up(link_up), .link(link.fabric_mp));
  xcvr_channel xcvr_channel_b_i (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(1'b1), .i_simplified(simp),
    .i_double_rate(dbl), .i_bonded(bonded), .i_master_align(align), .i_clk_sel_first(sel1), .i_clk_sel_second(sel2),
    .i_tx_cal_request(txcal), .i_rx_cal_request(rxcal), .i_serial_rx(ser_rx), .o_serial_tx(),
    .o_rx_bit(), .o_rx_shift(), .link(link2.device_mp));
  xcvr_link_sva xcvr_link_sva_i (.i_mclk(i_mclk), .i_reset(i_reset), .tx_analog_reset(link.tx_analog_reset),
    .tx_digital_reset(link.tx_digital_reset), .rx_analog_reset(link.rx_analog_reset),
    .rx_digital_reset(link.rx_digital_reset), .release_ctrl(link.release_ctrl), .tx_data(link.tx_data),
    .unused_tx_data(link.unused_tx_data), .tx_valid(link.tx_valid), .tx_ready(link.tx_ready),
    .tx_cal_busy(link.tx_cal_busy), .rx_cal_busy(link.rx_cal_busy), .tx_digital_status(link.tx_digital_status),
    .rx_digital_status(link.rx_digital_status), .dll_lock(link.dll_lock));
  initial begin
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    hist <= {serial_tx, hist[399:1]};
    prev_tx <= serial_tx;
    if (link.tx_valid === 1'b1 && link.tx_ready === 1'b0) begin
      stalls <= stalls + 1;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : step
  task automatic give_up(input int k, input int bound);
    if (k >= bound) begin
      fails++;
      tally_and_finish();
    end
  endtask : give_up
  task automatic do_reset();
    int k;
    k = 0;
    i_reset = 1'b1;
    step(6);
    i_reset = 1'b0;
    while (link_up !== 1'b1 && k < 3000) begin
      step(1);
      k++;
    end
    give_up(k, 3000);
    check(link.dll_lock, 1'b1);
    check({link.tx_cal_busy, link.rx_cal_busy}, 2'b00);
  endtask : do_reset
  task automatic send_word(input logic [71:0] w);
    int k;
    k = 0;
    word = w;
    word_valid = 1'b1;
    while (word_ready !== 1'b1 && k < 500) begin
      step(1);
      k++;
    end
    give_up(k, 500);
    step(1);
  endtask : send_word
  function automatic logic found(input logic [71:0] w);
    found = 1'b0;
    for (int i = 0; i <= 328; i++) begin
      if (hist[i +: 72] === w) found = 1'b1;
    end
  endfunction : found
  ////////////////////////////////////////////////////////////
  task automatic t_stream(input logic s, input logic d, input logic [7:0] m);
    int s0;
    simp = s;
    dbl = d;
    do_reset();
    s0 = stalls;
    for (int i = 0; i < 4; i++) send_word({m, 8'(i), 56'h5A_C3F0_1234_8765});
    word_valid = 1'b0;
    step(320);
    check(stalls > s0, 1'b1);
    for (int i = 0; i < 4; i++) check(found({m, 8'(i), 56'h5A_C3F0_1234_8765}), 1'b1);
  endtask : t_stream
  task automatic t_loop();
    logic [7:0] sh;
    lpbk = 1'b1;
    step(8);
    send_word(72'hC3_A5F0_0FF0_5A5A_9966);
    word_valid = 1'b0;
    for (int i = 0; i < 60; i++) begin
      step(1);
      check(rx_bit, prev_tx);
      if (i >= 8) check(rx_shift, sh);
      sh = {sh[6:0], rx_bit};
    end
    lpbk = 1'b0;
    step(8);
    ser_rx = 1'b1;
    step(1);
    check(rx_bit, 1'b1);
    ser_rx = 1'b0;
  endtask : t_loop
  task automatic t_clocks();
    logic [2:0] sel [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
    int rises [4] = '{16, 32, 8, 0};
    int n1, n2;
    logic p1, p2;
    bonded = 1'b1;
    align = 1'b1;
    step(1);
    align = 1'b0;
    for (int j = 0; j < 4; j++) begin
      sel1 = sel[j];
      sel2 = sel[(j + 1) % 4];
      step(4);
      n1 = 0;
      n2 = 0;
      p1 = link.transmit_clock_out;
      p2 = link.transmit_second_clock_out;
      repeat (64) begin
        step(1);
        n1 += int'(link.transmit_clock_out === 1'b1 && p1 === 1'b0);
        n2 += int'(link.transmit_second_clock_out === 1'b1 && p2 === 1'b0);
        p1 = link.transmit_clock_out;
        p2 = link.transmit_second_clock_out;
      end
      check(n1, rises[j]);
      check(n2, rises[(j + 1) % 4]);
    end
    ce = 1'b0;
    p2 = link.transmit_second_clock_out;
    repeat (3) begin
      step(1);
      check(link.transmit_second_clock_out, p2);
    end
    ce = 1'b1;
  endtask : t_clocks
  task automatic t_cal(input int which);
    int k;
    k = 0;
    txcal = (which == 0);
    rxcal = (which == 1);
    step(1);
    txcal = 1'b0;
    rxcal = 1'b0;
    step(2);
    check(which ? link.rx_cal_busy : link.tx_cal_busy, 1'b1);
    check({link_up, link.tx_digital_reset, link.rx_digital_reset}, 3'b011);
    while ((link.tx_cal_busy | link.rx_cal_busy) !== 1'b0 && k < 400) begin
      step(1);
      k++;
    end
    give_up(k, 400);
    check(k + 10 >= int'(xcvr_pkg::CAL_CYCLES) && k <= int'(xcvr_pkg::CAL_CYCLES), 1'b1);
    do_reset();
  endtask : t_cal
  task automatic t_gbx();
    int k;
    int n;
    k = 0;
    n = 0;
    gbx = 1'b1;
    step(1);
    gbx = 1'b0;
    while (link.release_ctrl !== 1'b1 && k < 5) begin
      step(1);
      k++;
    end
    give_up(k, 5);
    while (link.release_ctrl === 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    check(n, int'(xcvr_pkg::REL_CYCLES));
  endtask : t_gbx
  task automatic t_resets();
    logic [4:0] v;
    for (int i = 0; i < 6; i++) begin
      v = (i < 5) ? 5'(1 << i) : 5'h00;
      {link2.release_ctrl, link2.rx_digital_reset, link2.rx_analog_reset, link2.tx_digital_reset,
        link2.tx_analog_reset} = v;
      step(8);
      check({link2.rx_digital_status, link2.rx_analog_status, link2.tx_digital_status, link2.tx_analog_status},
        v[3:0] | {2'b00, v[4], 1'b0});
    end
  endtask : t_resets
  ////////////////////////////////////////////////////////////
  initial begin
    {link2.release_ctrl, link2.rx_digital_reset, link2.rx_analog_reset} = 3'b000;
    {link2.tx_digital_reset, link2.tx_analog_reset, link2.loopback_enable, link2.tx_valid} = 4'h0;
    link2.tx_data = '0;
    link2.tx_control = 8'h00;
    link2.unused_tx_data = 16'h0000;
    t_stream(1'b0, 1'b0, 8'h11);
    t_stream(1'b1, 1'b0, 8'h22);
    t_stream(1'b0, 1'b1, 8'h33);
    t_stream(1'b1, 1'b1, 8'h44);
    t_loop();
    t_clocks();
    t_cal(0);
    t_cal(1);
    t_gbx();
    t_resets();
    tally_and_finish();
  end
endmodule : xcvr_channel_core_interface_tb_top
